// file: logic/host_port_pkg.sv
// constants, modes and carriers shared by the host control port
package host_port_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int DEPTH = 64;
	localparam int BIT_CNT_W = 5;
	// serial frame: command byte, turnaround or write byte, read byte
	localparam logic [4:0] CMD_LAST = 5'h07;
	localparam logic [4:0] MID_LAST = 5'h0f;
	localparam logic [4:0] FRAME_LAST = 5'h17;
	// command byte fields, sent least significant bit first
	localparam int CMD_RD_BIT = 0;
	localparam int CMD_ADDR_LSB = 1;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [5:0] ADDR_RESET = 6'h00;
	// interface select codes on the mode straps
	localparam logic [1:0] MODE_HW = 2'h0;
	localparam logic [1:0] MODE_SERIAL = 2'h1;
	localparam logic [1:0] MODE_STROBE_DIR = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;

	typedef enum logic [2:0] {
		PAR_IDLE = 3'b001,
		PAR_READ = 3'b010,
		PAR_WRITE = 3'b100
	} par_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} access_s;

	// parallel pins as sampled by the synchroniser
	typedef struct packed {
		logic chip_select_n;
		logic strobe_n;
		logic dir_or_put_n;
		logic [1:0] mode;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} pins_s;

	localparam pins_s PINS_IDLE = '{chip_select_n: 1'b1, strobe_n: 1'b1, dir_or_put_n: 1'b1,
		mode: MODE_HW, addr: ADDR_RESET, data: DATA_RESET};
	localparam access_s ACCESS_RESET = '{addr: ADDR_RESET, data: DATA_RESET};
endpackage : host_port_pkg

// file: logic/host_control_port.sv
// host control port: serial and parallel access to the configuration space
`timescale 1ns/1ps
`default_nettype none
module host_control_port #(
	parameter int IRQ_N = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic shift_clock,
	input wire logic chip_select_n,
	input wire logic serial_in,
	output logic serial_out,
	input wire logic output_edge_select,
	input wire logic data_strobe_n,
	input wire logic direction_select,
	input wire logic [1:0] bus_mode,
	input wire logic [host_port_pkg::ADDR_W-1:0] addr,
	input wire logic [host_port_pkg::DATA_W-1:0] data_in,
	output logic [host_port_pkg::DATA_W-1:0] data_out,
	output logic data_oe,
	output logic write_valid,
	output var host_port_pkg::access_s write_access,
	input wire logic [IRQ_N-1:0] irq_pending,
	input wire logic [IRQ_N-1:0] irq_enable,
	output logic host_irq_out
);
	// configuration space
	logic [host_port_pkg::DATA_W-1:0] mem [host_port_pkg::DEPTH];

	function automatic logic mode_is(input logic [1:0] m, input logic [1:0] code);
		mode_is = (m == code);
	endfunction : mode_is

	// clk domain: pin synchroniser
	host_port_pkg::pins_s pins_raw;
	host_port_pkg::pins_s pins_s1;
	host_port_pkg::pins_s pins_s2;
	assign pins_raw = '{chip_select_n: chip_select_n, strobe_n: data_strobe_n,
		dir_or_put_n: direction_select, mode: bus_mode, addr: addr, data: data_in};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_s1 <= host_port_pkg::PINS_IDLE;
			pins_s2 <= host_port_pkg::PINS_IDLE;
		end else begin
			pins_s1 <= pins_raw;
			pins_s2 <= pins_s1;
		end
	end

	// parallel access decode
	logic par_rd;
	logic par_wr;
	always_comb begin
		par_rd = 1'b0;
		par_wr = 1'b0;
		if (!pins_s2.chip_select_n) begin
			if (mode_is(pins_s2.mode, host_port_pkg::MODE_STROBE_DIR)) begin
				par_rd = !pins_s2.strobe_n && pins_s2.dir_or_put_n;
				par_wr = !pins_s2.strobe_n && !pins_s2.dir_or_put_n;
			end else if (mode_is(pins_s2.mode, host_port_pkg::MODE_SPLIT)) begin
				par_rd = !pins_s2.strobe_n;
				par_wr = !pins_s2.dir_or_put_n && pins_s2.strobe_n;
			end
		end
	end

	host_port_pkg::par_state_e par_state;
	host_port_pkg::par_state_e next_par_state;
	host_port_pkg::access_s par_hold;
	logic par_commit;

	always_comb begin
		next_par_state = par_state;
		par_commit = 1'b0;
		case (par_state)
			host_port_pkg::PAR_IDLE: begin
				if (par_rd) begin
					next_par_state = host_port_pkg::PAR_READ;
				end else if (par_wr) begin
					next_par_state = host_port_pkg::PAR_WRITE;
				end
			end
			host_port_pkg::PAR_READ: begin
				if (!par_rd) begin
					next_par_state = host_port_pkg::PAR_IDLE;
				end
			end
			host_port_pkg::PAR_WRITE: begin
				if (!par_wr) begin
					next_par_state = host_port_pkg::PAR_IDLE;
					par_commit = 1'b1;
				end
			end
			default: begin
				next_par_state = host_port_pkg::PAR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			par_state <= host_port_pkg::PAR_IDLE;
		end else begin
			par_state <= next_par_state;
		end
	end

	// write data and address follow the bus while par_wr is set: put low with strobe high in split mode, strobe and direction low in strobe/direction mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			par_hold <= host_port_pkg::ACCESS_RESET;
		end else if (par_wr) begin
			par_hold <= '{addr: pins_s2.addr, data: pins_s2.data};
		end
	end

	// read data is sampled once at strobe start and held on the bus
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= host_port_pkg::DATA_RESET;
		end else if (par_state == host_port_pkg::PAR_IDLE && par_rd) begin
			data_out <= mem[pins_s2.addr];
		end
	end

	assign data_oe = (par_state == host_port_pkg::PAR_READ);

	// link domain: serial frame
	logic link_rst_n;
	assign link_rst_n = rst_n & ~chip_select_n;

	logic [host_port_pkg::BIT_CNT_W-1:0] bit_cnt;
	logic [7:0] in_sr;
	logic [7:0] out_sr;
	logic cmd_read;
	logic [7:0] in_next;
	assign in_next = {serial_in, in_sr[7:1]};

	always_ff @(posedge shift_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt <= '0;
			in_sr <= host_port_pkg::DATA_RESET;
			cmd_read <= 1'b0;
		end else begin
			in_sr <= in_next;
			if (bit_cnt != host_port_pkg::FRAME_LAST) begin
				bit_cnt <= bit_cnt + 5'h01;
			end
			if (bit_cnt == host_port_pkg::CMD_LAST) begin
				cmd_read <= in_next[host_port_pkg::CMD_RD_BIT];
			end
		end
	end

	// request words and toggles stay across frames, reset only by rst_n
	logic [host_port_pkg::ADDR_W-1:0] ser_addr;
	logic [host_port_pkg::DATA_W-1:0] ser_wdata;
	logic wr_tog;
	logic rd_tog;
	always_ff @(posedge shift_clock or negedge rst_n) begin
		if (!rst_n) begin
			ser_addr <= host_port_pkg::ADDR_RESET;
			ser_wdata <= host_port_pkg::DATA_RESET;
			wr_tog <= 1'b0;
			rd_tog <= 1'b0;
		end else if (!chip_select_n) begin
			if (bit_cnt == host_port_pkg::CMD_LAST) begin
				ser_addr <= in_next[host_port_pkg::CMD_ADDR_LSB +: host_port_pkg::ADDR_W];
				if (in_next[host_port_pkg::CMD_RD_BIT]) begin
					rd_tog <= ~rd_tog;
				end
			end
			if (bit_cnt == host_port_pkg::MID_LAST && !cmd_read) begin
				ser_wdata <= in_next;
				wr_tog <= ~wr_tog;
			end
		end
	end

	// read answer crosses back to the link domain
	logic [host_port_pkg::DATA_W-1:0] ser_rdata;
	logic rd_ack;
	logic ack_s1;
	logic ack_s2;
	always_ff @(posedge shift_clock or negedge rst_n) begin
		if (!rst_n) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= rd_ack;
			ack_s2 <= ack_s1;
		end
	end

	always_ff @(posedge shift_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			out_sr <= host_port_pkg::DATA_RESET;
		end else if (bit_cnt == host_port_pkg::MID_LAST) begin
			out_sr <= (cmd_read && ack_s2 == rd_tog) ? ser_rdata : host_port_pkg::DATA_RESET;
		end else begin
			out_sr <= {1'b0, out_sr[7:1]};
		end
	end

	// falling edge launch copies the rising edge bit half a period later
	logic edge_s1;
	logic edge_s2;
	logic out_fall;
	always_ff @(posedge shift_clock or negedge rst_n) begin
		if (!rst_n) begin
			edge_s1 <= 1'b0;
			edge_s2 <= 1'b0;
		end else begin
			edge_s1 <= output_edge_select;
			edge_s2 <= edge_s1;
		end
	end

	always_ff @(negedge shift_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			out_fall <= 1'b0;
		end else begin
			out_fall <= out_sr[0];
		end
	end

	assign serial_out = edge_s2 ? out_fall : out_sr[0];

	// clk domain: serial request crossing
	logic wt_s1;
	logic wt_s2;
	logic wt_s3;
	logic rt_s1;
	logic rt_s2;
	logic rt_s3;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wt_s1 <= 1'b0;
			wt_s2 <= 1'b0;
			wt_s3 <= 1'b0;
			rt_s1 <= 1'b0;
			rt_s2 <= 1'b0;
			rt_s3 <= 1'b0;
		end else begin
			wt_s1 <= wr_tog;
			wt_s2 <= wt_s1;
			wt_s3 <= wt_s2;
			rt_s1 <= rd_tog;
			rt_s2 <= rt_s1;
			rt_s3 <= rt_s2;
		end
	end

	logic ser_commit;
	logic ser_read;
	assign ser_commit = (wt_s2 ^ wt_s3) && mode_is(pins_s2.mode, host_port_pkg::MODE_SERIAL);
	assign ser_read = rt_s2 ^ rt_s3;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_rdata <= host_port_pkg::DATA_RESET;
			rd_ack <= 1'b0;
		end else if (ser_read) begin
			ser_rdata <= mem[ser_addr];
			rd_ack <= rt_s2;
		end
	end

	// storage and write event to the device core
	always_ff @(posedge clk) begin
		if (par_commit) begin
			mem[par_hold.addr] <= par_hold.data;
		end else if (ser_commit) begin
			mem[ser_addr] <= ser_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_valid <= 1'b0;
			write_access <= host_port_pkg::ACCESS_RESET;
		end else begin
			write_valid <= par_commit | ser_commit;
			if (par_commit) begin
				write_access <= par_hold;
			end else if (ser_commit) begin
				write_access <= '{addr: ser_addr, data: ser_wdata};
			end
		end
	end

	// combined interrupt request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_irq_out <= 1'b0;
		end else begin
			host_irq_out <= |(irq_pending & irq_enable);
		end
	end
endmodule : host_control_port
`default_nettype wire

// file: verif/host_control_port_sva.sv
// checker for the host control port
`timescale 1ns/1ps
`default_nettype none
module port_checker #(parameter int IRQ_N = 8) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic chip_select_n,
	input wire logic serial_out,
	input wire logic data_strobe_n,
	input wire logic direction_select,
	input wire logic [1:0] bus_mode,
	input wire logic [5:0] addr,
	input wire logic [7:0] data_in,
	input wire logic data_oe,
	input wire logic write_valid,
	input wire host_port_pkg::access_s write_access,
	input wire logic [IRQ_N-1:0] irq_pending,
	input wire logic [IRQ_N-1:0] irq_enable,
	input wire logic host_irq_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	oe_start_a: assert property ($rose(data_oe) |-> !$past(chip_select_n, 2) && !$past(data_strobe_n, 2)
		&& $past(bus_mode[1], 2) && ($past(direction_select, 2) || $past(bus_mode[0], 2))) else $error("bad drive");
	oe_stop_a: assert property ($rose(data_strobe_n) && data_oe |-> ##[1:4] !data_oe) else $error("no release");
	cs_quiet_a: assert property (chip_select_n [*6] |-> !write_valid && !data_oe) else $error("busy");
	one_pulse_a: assert property (write_valid |=> !write_valid) else $error("long pulse");
	split_wr_a: assert property ($rose(direction_select) && !chip_select_n
		&& bus_mode == host_port_pkg::MODE_SPLIT |-> ##[3:6] write_valid) else $error("no write");
	dir_wr_a: assert property ($rose(data_strobe_n) && !direction_select && !chip_select_n
		&& bus_mode == host_port_pkg::MODE_STROBE_DIR |-> ##[3:6] write_valid) else $error("no write");
	wr_data_a: assert property ($rose(write_valid) && bus_mode[1]
		|-> write_access == {$past(addr, 4), $past(data_in, 4)}) else $error("bad write");
	irq_a: assert property ($past(rst_n) |-> host_irq_out == |($past(irq_pending) & $past(irq_enable)))
		else $error("bad irq");
	idle_out_a: assert property (chip_select_n && $past(chip_select_n, 2) |-> !serial_out) else $error("out");
endmodule : port_checker
bind host_control_port port_checker #(.IRQ_N(IRQ_N)) pins_chk (.clk(clk), .rst_n(rst_n),
	.chip_select_n(chip_select_n), .serial_out(serial_out), .data_strobe_n(data_strobe_n),
	.direction_select(direction_select), .bus_mode(bus_mode), .addr(addr), .data_in(data_in),
	.data_oe(data_oe), .write_valid(write_valid), .write_access(write_access),
	.irq_pending(irq_pending), .irq_enable(irq_enable), .host_irq_out(host_irq_out));
`default_nettype wire

// file: verif/serial_host.sv
// host model driving serial frames
`timescale 1ns/1ps
`default_nettype none
module serial_host (
	output logic shift_clock,
	output logic cs_n,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic edge_sel
);
	initial {shift_clock, cs_n, serial_in} = 3'h2;
	task automatic frame(input logic rd, input logic [5:0] a, input logic [7:0] wd, output logic [7:0] q);
		logic [23:0] v;
		v = {8'h00, wd, 1'b0, a, rd};
		q = 8'h00;
		#17 cs_n = 1'b0;
		for (int k = 0; k < 24; k++) begin
			serial_in = v[k];
			#40;
			if (edge_sel && k > 15) q[k-16] = serial_out;
			shift_clock = 1'b1;
			#40;
			if (!edge_sel && k > 14 && k < 23) q[k-15] = serial_out;
			shift_clock = 1'b0;
		end
		#20 cs_n = 1'b1;
		serial_in = ~serial_in;
	endtask : frame
endmodule : serial_host
`default_nettype wire

// file: verif/tb_host_control_port.sv
// testbench for the host control port
`timescale 1ns/1ps
`default_nettype none
module tb_host_control_port;
	logic clk, rst_n, sel, pcs_n, ds_n, dir, seen, live;
	logic [1:0] mode;
	logic [5:0] a;
	logic [7:0] d, v, pend, en, mem[64];
	wire logic sck, scs_n, sin, sout, oe, wv, irq;
	wire logic [7:0] dout;
	wire host_port_pkg::access_s wa;
	logic [13:0] wq[$];
	logic [7:0] rq[$];
	int errors, num_checks;
	host_control_port uut (.clk(clk), .rst_n(rst_n), .shift_clock(sck), .chip_select_n(pcs_n & scs_n),
		.serial_in(sin), .serial_out(sout), .output_edge_select(sel), .data_strobe_n(ds_n),
		.direction_select(dir), .bus_mode(mode), .addr(a), .data_in(d), .data_out(dout), .data_oe(oe),
		.write_valid(wv), .write_access(wa), .irq_pending(pend), .irq_enable(en), .host_irq_out(irq));
	serial_host sh (.shift_clock(sck), .cs_n(scs_n), .serial_in(sin), .serial_out(sout), .edge_sel(sel));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	always @(negedge clk) begin
		if (wv === 1'b1) chk(wa, wq.size() ? wq.pop_front() : 'x);
		if (oe === 1'b1 && !seen) chk({6'h0, dout}, rq.size() ? {6'h0, rq.pop_front()} : 'x);
		seen <= oe === 1'b1;
		if (live && rst_n) chk({13'h0, irq}, {13'h0, |(pend & en)});
		live <= rst_n;
		{pend, en} <= 16'($urandom);
	end
	task automatic par(input logic [1:0] m, input logic rd, input logic [5:0] ad, input logic [7:0] dv, input logic c);
		logic ok;
		ok = m[1] && !c;
		mode = m;
		a = ad;
		d = dv;
		pcs_n = c;
		dir = m[0] ? 1'b1 : rd;
		if (ok && rd) rq.push_back(mem[ad]);
		if (ok && !rd) wq.push_back({ad, dv});
		if (ok && !rd) mem[ad] = dv;
		cyc(1);
		if (rd || !m[0]) ds_n = 1'b0;
		else dir = 1'b0;
		cyc(5);
		chk({13'h0, oe}, {13'h0, ok && rd});
		ds_n = 1'b1;
		if (m[0]) dir = 1'b1;
		cyc(4);
		chk({13'h0, oe}, 14'h0);
		pcs_n = 1'b1;
		cyc(4);
	endtask : par
	task automatic ser(input logic rd, input logic [5:0] ad, input logic [7:0] dv);
		logic [7:0] r;
		mode = host_port_pkg::MODE_SERIAL;
		if (!rd) wq.push_back({ad, dv});
		if (!rd) mem[ad] = dv;
		cyc(3);
		sh.frame(rd, ad, dv, r);
		if (rd) chk({6'h0, r}, {6'h0, mem[ad]});
		cyc(8);
	endtask : ser
	initial begin
		{rst_n, sel, seen, live, mode, a, d, v, pend, en} = '0;
		{pcs_n, ds_n, dir} = 3'h7;
		errors = 0;
		num_checks = 0;
		void'($urandom(32'he9a5));
		cyc(2);
		rst_n = 1'b1;
		cyc(3);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			par(i[0] ? host_port_pkg::MODE_SPLIT : host_port_pkg::MODE_STROBE_DIR, 1'b0, 6'(i * 21), v, 1'b0);
			par(i[0] ? host_port_pkg::MODE_SPLIT : host_port_pkg::MODE_STROBE_DIR, 1'b1, 6'(i * 21), v, 1'b0);
		end
		par(host_port_pkg::MODE_HW, 1'b0, 6'h3f, ~v, 1'b0);
		par(host_port_pkg::MODE_SPLIT, 1'b0, 6'h3f, ~v, 1'b1);
		par(host_port_pkg::MODE_STROBE_DIR, 1'b1, 6'h3f, v, 1'b1);
		par(host_port_pkg::MODE_SPLIT, 1'b1, 6'h3f, v, 1'b0);
		rst_n = 1'b0;
		cyc(2);
		chk({10'h0, wv, oe, irq, sout}, 14'h0);
		rst_n = 1'b1;
		cyc(3);
		for (int s = 0; s < 2; s++) begin
			sel = s[0];
			v = 8'($urandom);
			ser(1'b0, 6'h05, v);
			ser(1'b1, 6'h05, v);
			ser(1'b1, 6'h2a, v);
		end
		give_verdict();
	end
	initial begin
		#2000000;
		errors++;
		give_verdict();
	end
endmodule : tb_host_control_port
`default_nettype wire
